// ### sssr_regs.sv
// Functional notes
// - receiver_on sets on command; clears only when receiver idle after off
// - transmitter_on sets on command; clears when transmitter idle after off
// - receive sync event sets the receive sync flag
// - transmit sync event sets the transmit sync flag
// - second compare match sets compare flag b
// - first compare match sets compare flag a
// - status read clears sticky flags, returns values before clear
// - overrun sets when a word lands on an unread word
// - rx ready sets on load, clears when holding register emptied
// - tx empty sets when last word shifted out completely
// - tx empty low while holding or shifter holds a word
// - tx holding free high when holding register empty
// - enable-set write of one sets the mask bit
// - enable-clear write of one clears the mask bit
// - zero written to set or clear leaves mask unchanged
// - mask register readable, resets to zero
// - rx sync holding read-only, upper bits zero
// - tx sync holding read/write 16-bit
// - two 16-bit compare registers, reset zero
// - sync word shifted out during tx sync when enabled
// - edge select picks rising or falling transmit sync edge; receive sync is always taken on its rising edge
module sssr_regs
    import sssr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // receive side from the receiver
    input wire logic rx_load,
    input wire logic [31:0] rx_word,
    input wire logic rx_busy,
    input wire logic rx_sync_capture,
    input wire logic [SYNC_W-1:0] rx_sync_word,
    // pins
    input wire logic tx_frame_sync_pin,
    input wire logic rx_frame_sync_pin,
    // outputs
    output logic tx_data_sync,
    output logic irq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] rx_sync_hold;
    logic [SYNC_W-1:0] tx_sync_hold;
    logic [SYNC_W-1:0] cmp_a;
    logic [SYNC_W-1:0] cmp_b;
    logic [31:0] mask;
    logic receiver_on;
    logic transmitter_on;
    logic rx_off_pend;
    logic tx_off_pend;
    logic rx_frame_sync_event;
    logic tx_frame_sync_event;
    logic compare_match_a;
    logic compare_match_b;
    logic rx_overflow_flag;
    logic rx_word_ready;
    logic [31:0] rx_holding_word;
    logic tx_full;
    logic [31:0] tx_holding_word;
    logic edge_sel;
    logic send_en;
    logic [SYNC_LEN_W-1:0] sync_len;
    logic rx_fs_d;
    logic [1:0] pins_s;

    sssr_bus_if ev ();

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    sssr_rx_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({rx_frame_sync_pin, tx_frame_sync_pin}),
        .pin_sync(pins_s)
    );

    sssr_tx_line u_tx (
        .clk_sys(clk_sys),
        .rst(rst),
        .fs_sync(pins_s[0]),
        .edge_sel(edge_sel),
        .send_en(send_en),
        .sync_len(sync_len),
        .sync_word(tx_sync_hold),
        .holding_full(tx_full),
        .tx_on(transmitter_on),
        .ev(ev.src)
    );

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire wr_cmd = reg_wr && (reg_addr == OFS_COMMAND);
    wire wr_mode = reg_wr && (reg_addr == OFS_SYNC_MODE);
    wire wr_thr = reg_wr && (reg_addr == OFS_TX_HOLDING);
    wire wr_tsh = reg_wr && (reg_addr == OFS_TX_SYNC_HOLDING);
    wire wr_ca = reg_wr && (reg_addr == OFS_RX_COMPARE_A);
    wire wr_cb = reg_wr && (reg_addr == OFS_RX_COMPARE_B);
    wire wr_ier = reg_wr && (reg_addr == OFS_IRQ_ENABLE_SET);
    wire wr_idr = reg_wr && (reg_addr == OFS_IRQ_ENABLE_CLEAR);
    wire rd_sr = reg_rd && (reg_addr == OFS_EVENT_STATUS);
    wire rd_rhr = reg_rd && (reg_addr == OFS_RX_HOLDING);

    // receive frame sync is taken on its rising edge
    wire rx_sync_hit = pins_s[1] & ~rx_fs_d;
    wire [15:0] rx_low = rx_word[15:0];
    wire hit_a = rx_load && (rx_low == cmp_a);
    wire hit_b = rx_load && (rx_low == cmp_b);
    wire tx_all_done = ~tx_full & ~ev.tx_busy;
    wire tx_holding_free = ~tx_full;

    // live status word; reserved bits stay zero
    wire [31:0] status_now = {
        14'h0000, receiver_on, transmitter_on,
        4'h0, rx_frame_sync_event, tx_frame_sync_event,
        compare_match_b, compare_match_a,
        2'h0, rx_overflow_flag, rx_word_ready,
        2'h0, tx_all_done, tx_holding_free
    };

    logic [31:0] next_rdata;
    // read mux; unmapped addresses return zero
    always_comb begin
        if (reg_addr == OFS_RX_SYNC_HOLDING) begin
            next_rdata = {16'h0000, rx_sync_hold};
        end else if (reg_addr == OFS_TX_SYNC_HOLDING) begin
            next_rdata = {16'h0000, tx_sync_hold};
        end else if (reg_addr == OFS_RX_COMPARE_A) begin
            next_rdata = {16'h0000, cmp_a};
        end else if (reg_addr == OFS_RX_COMPARE_B) begin
            next_rdata = {16'h0000, cmp_b};
        end else if (reg_addr == OFS_EVENT_STATUS) begin
            next_rdata = status_now;
        end else if (reg_addr == OFS_IRQ_MASK_STATE) begin
            next_rdata = mask;
        end else if (reg_addr == OFS_RX_HOLDING) begin
            next_rdata = rx_holding_word;
        end else if (reg_addr == OFS_SYNC_MODE) begin
            next_rdata = {7'h00, edge_sel, send_en, 19'h00000, sync_len};
        end else begin
            next_rdata = 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // register read data and interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
            irq <= 1'b0;
            tx_data_sync <= 1'b0;
            rx_fs_d <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
            irq <= |(status_now & mask);
            tx_data_sync <= ev.tx_sync_bit;
            rx_fs_d <= pins_s[1];
        end
    end

    // ---------------------------------------------------------------
    // software-written configuration
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_sync_hold <= WORD16_RESET;
            cmp_a <= WORD16_RESET;
            cmp_b <= WORD16_RESET;
            edge_sel <= 1'b0;
            send_en <= 1'b0;
            sync_len <= '0;
        end else begin
            if (wr_tsh) begin
                tx_sync_hold <= reg_wdata[SYNC_W-1:0];
            end
            if (wr_ca) begin
                cmp_a <= reg_wdata[SYNC_W-1:0];
            end
            if (wr_cb) begin
                cmp_b <= reg_wdata[SYNC_W-1:0];
            end
            if (wr_mode) begin
                edge_sel <= reg_wdata[MODE_EDGE];
                send_en <= reg_wdata[MODE_SEND];
                sync_len <= reg_wdata[SYNC_LEN_W-1:0];
            end
        end
    end

    // mask: set wins nothing over clear; zeros are no-ops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask <= MASK_RESET;
        end else if (wr_ier) begin
            mask <= mask | (reg_wdata & IRQ_BITS_MASK);
        end else if (wr_idr) begin
            mask <= mask & ~(reg_wdata & IRQ_BITS_MASK);
        end
    end

    // ---------------------------------------------------------------
    // enables: an off command waits until the side is idle
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            receiver_on <= 1'b0;
            transmitter_on <= 1'b0;
            rx_off_pend <= 1'b0;
            tx_off_pend <= 1'b0;
        end else begin
            if (wr_cmd && reg_wdata[CMD_RX_ON]) begin
                receiver_on <= 1'b1;
                rx_off_pend <= 1'b0;
            end else if (wr_cmd && reg_wdata[CMD_RX_OFF]) begin
                rx_off_pend <= 1'b1;
            end else if (rx_off_pend && !rx_busy) begin
                receiver_on <= 1'b0;
                rx_off_pend <= 1'b0;
            end
            if (wr_cmd && reg_wdata[CMD_TX_ON]) begin
                transmitter_on <= 1'b1;
                tx_off_pend <= 1'b0;
            end else if (wr_cmd && reg_wdata[CMD_TX_OFF]) begin
                tx_off_pend <= 1'b1;
            end else if (tx_off_pend && !ev.tx_busy && !tx_full) begin
                transmitter_on <= 1'b0;
                tx_off_pend <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // sticky events: a set in the clearing cycle wins
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_frame_sync_event <= 1'b0;
            tx_frame_sync_event <= 1'b0;
            compare_match_a <= 1'b0;
            compare_match_b <= 1'b0;
            rx_overflow_flag <= 1'b0;
            rx_sync_hold <= WORD16_RESET;
        end else begin
            rx_frame_sync_event <= rx_sync_hit |
                (rx_frame_sync_event & ~rd_sr);
            tx_frame_sync_event <= ev.tx_sync_pulse |
                (tx_frame_sync_event & ~rd_sr);
            compare_match_a <= hit_a | (compare_match_a & ~rd_sr);
            compare_match_b <= hit_b | (compare_match_b & ~rd_sr);
            rx_overflow_flag <= (rx_load & rx_word_ready & ~rd_rhr) |
                (rx_overflow_flag & ~rd_sr);
            if (rx_sync_capture) begin
                rx_sync_hold <= rx_sync_word;
            end
        end
    end

    // ---------------------------------------------------------------
    // receive and transmit holding words
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_word_ready <= 1'b0;
            rx_holding_word <= 32'h00000000;
            tx_full <= 1'b0;
            tx_holding_word <= 32'h00000000;
        end else begin
            if (rx_load) begin
                rx_word_ready <= 1'b1;
                rx_holding_word <= rx_word;
            end else if (rd_rhr) begin
                rx_word_ready <= 1'b0;
            end
            if (wr_thr) begin
                tx_full <= 1'b1;
                tx_holding_word <= reg_wdata;
            end else if (ev.tx_load) begin
                tx_full <= 1'b0;
            end
        end
    end
endmodule : sssr_regs

// ### sssr_pkg.sv
package sssr_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_RX_SYNC_HOLDING = 8'h30;
    localparam logic [7:0] OFS_TX_SYNC_HOLDING = 8'h34;
    localparam logic [7:0] OFS_RX_COMPARE_A = 8'h38;
    localparam logic [7:0] OFS_RX_COMPARE_B = 8'h3C;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h40;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h44;
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h48;
    localparam logic [7:0] OFS_IRQ_MASK_STATE = 8'h4C;
    // command register of this block (not printed in the map)
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    // frame mode bits of this block (edge select, sync send, length)
    localparam logic [7:0] OFS_SYNC_MODE = 8'h1C;
    localparam logic [7:0] OFS_TX_HOLDING = 8'h24;
    localparam logic [7:0] OFS_RX_HOLDING = 8'h20;

    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int BIT_TX_HOLDING_FREE = 0;
    localparam int BIT_TX_ALL_DONE = 1;
    localparam int BIT_RX_WORD_READY = 4;
    localparam int BIT_RX_OVERFLOW = 5;
    localparam int BIT_COMPARE_A = 8;
    localparam int BIT_COMPARE_B = 9;
    localparam int BIT_TX_SYNC_EVENT = 10;
    localparam int BIT_RX_SYNC_EVENT = 11;
    localparam int BIT_TRANSMITTER_ON = 16;
    localparam int BIT_RECEIVER_ON = 17;
    // bits that may be masked onto the interrupt line
    localparam logic [31:0] IRQ_BITS_MASK = 32'h00000F33;
    localparam logic [31:0] STATUS_RESET = 32'h000000CC;
    localparam logic [31:0] MASK_RESET = 32'h00000000;

    // command bits
    localparam int CMD_RX_ON = 0;
    localparam int CMD_RX_OFF = 1;
    localparam int CMD_TX_ON = 8;
    localparam int CMD_TX_OFF = 9;
    // sync mode bits
    localparam int MODE_EDGE = 24;
    localparam int MODE_SEND = 23;
    localparam int MODE_LEN_LSB = 0;
    localparam int SYNC_LEN_W = 4;
    localparam int SYNC_W = 16;
    localparam logic [15:0] WORD16_RESET = 16'h0000;
endpackage : sssr_pkg

// ### sssr_bus_if.sv
// status events that flow from the line logic into the register core
interface sssr_bus_if;
    logic tx_sync_pulse;
    logic tx_load;
    logic tx_busy;
    logic tx_sync_bit;
    modport src (output tx_sync_pulse, output tx_load, output tx_busy,
        output tx_sync_bit);
    modport dst (input tx_sync_pulse, input tx_load, input tx_busy,
        input tx_sync_bit);
endinterface : sssr_bus_if

// ### sssr_tx_line.sv
// -------------------------------------------------------------------
// transmit sync edge detect, sync word shifting and shifter model
// -------------------------------------------------------------------
module sssr_tx_line
    import sssr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // controls
    input wire logic fs_sync,
    input wire logic edge_sel,
    input wire logic send_en,
    input wire logic [SYNC_LEN_W-1:0] sync_len,
    input wire logic [SYNC_W-1:0] sync_word,
    input wire logic holding_full,
    input wire logic tx_on,
    // events out
    sssr_bus_if.src ev
);
    logic fs_d;
    logic [4:0] bit_cnt;
    logic [SYNC_W-1:0] shreg;
    logic [4:0] busy_cnt;
    wire rise = fs_sync & ~fs_d;
    wire fall = ~fs_sync & fs_d;
    wire sync_hit = edge_sel ? fall : rise;
    wire load = holding_full & tx_on & (busy_cnt == 5'h00);

    // each loaded word keeps the shifter busy for 16 clocks, standing in for the bit shifter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fs_d <= 1'b0;
            bit_cnt <= 5'h00;
            shreg <= WORD16_RESET;
            busy_cnt <= 5'h00;
        end else begin
            fs_d <= fs_sync;
            if (sync_hit && send_en) begin
                shreg <= sync_word;
                bit_cnt <= {1'b0, sync_len} + 5'h01;
            end else if (bit_cnt != 5'h00) begin
                shreg <= {1'b0, shreg[SYNC_W-1:1]};
                bit_cnt <= bit_cnt - 5'h01;
            end
            if (load) begin
                busy_cnt <= 5'h10;
            end else if (busy_cnt != 5'h00) begin
                busy_cnt <= busy_cnt - 5'h01;
            end
        end
    end

    assign ev.tx_sync_pulse = sync_hit;
    assign ev.tx_load = load;
    assign ev.tx_busy = busy_cnt != 5'h00;
    assign ev.tx_sync_bit = (bit_cnt != 5'h00) & shreg[0];
endmodule : sssr_tx_line

// ### sssr_rx_sync.sv
// -------------------------------------------------------------------
// two-stage synchroniser for pin inputs
// -------------------------------------------------------------------
module sssr_rx_sync
    import sssr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    logic [1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            meta <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule : sssr_rx_sync

// ### sssr_regs_asserts.sv
module sssr_regs_asserts
    import sssr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // receive side
    input wire logic rx_load,
    input wire logic [31:0] rx_word,
    input wire logic rx_busy,
    input wire logic rx_sync_capture,
    input wire logic [SYNC_W-1:0] rx_sync_word,
    // pins and outputs
    input wire logic tx_frame_sync_pin,
    input wire logic rx_frame_sync_pin,
    input wire logic tx_data_sync,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ---------------------------------------------------------------
    // quiet counter: cycles since the last pin change or word load
    // ---------------------------------------------------------------
    logic [2:0] quiet;
    logic [1:0] pins_q;
    wire logic [1:0] pins_now = {tx_frame_sync_pin, rx_frame_sync_pin};
    wire logic noisy = rx_load || (pins_q != pins_now);
    wire logic [2:0] next_quiet = noisy ? 3'h0 :
        ((quiet == 3'h7) ? quiet : quiet + 3'h1);
    wire logic rd_st = reg_rd && (reg_addr == OFS_EVENT_STATUS);
    wire logic rd_mk = reg_rd && (reg_addr == OFS_IRQ_MASK_STATE);
    // saturates so a long idle spell cannot wrap back to zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            quiet <= 3'h0;
            pins_q <= 2'h0;
        end else begin
            quiet <= next_quiet;
            pins_q <= pins_now;
        end
    end
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    status_rsvd_a: assert property ($past(rd_st) |->
        (reg_rdata & ~32'h00030F33) == 32'h0)
        else $error("status reserved bits not zero");
    sync_upper_a: assert property ($past(reg_rd) &&
        $past(reg_addr[7:4]) == 4'h3 |-> reg_rdata[31:16] == 16'h0)
        else $error("upper half of a 16-bit register not zero");
    mask_rsvd_a: assert property ($past(rd_mk) |->
        (reg_rdata & ~IRQ_BITS_MASK) == 32'h0)
        else $error("mask register reserved bits not zero");
    clear_on_rd_a: assert property ((rd_st && quiet > 3'h5) ##1
        (rd_st && quiet > 3'h5) |=> (reg_rdata & 32'h00000F20) == 32'h0)
        else $error("sticky flags survived a status read");
    mask_set_a: assert property ((reg_wr &&
        reg_addr == OFS_IRQ_ENABLE_SET) ##1 rd_mk |=>
        (reg_rdata & $past(reg_wdata, 2) & IRQ_BITS_MASK) ==
        ($past(reg_wdata, 2) & IRQ_BITS_MASK))
        else $error("enable-set write did not set mask bits");
    mask_clr_a: assert property ((reg_wr &&
        reg_addr == OFS_IRQ_ENABLE_CLEAR) ##1 rd_mk |=>
        (reg_rdata & $past(reg_wdata, 2)) == 32'h0)
        else $error("enable-clear write did not clear mask bits");
    irq_masked_a: assert property ($past(rd_mk) &&
        reg_rdata == 32'h0 |-> !irq)
        else $error("interrupt high with an empty mask");
endmodule : sssr_regs_asserts

bind sssr_regs sssr_regs_asserts u_chk (.clk_sys, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_load, .rx_word, .rx_busy,
    .rx_sync_capture, .rx_sync_word, .tx_frame_sync_pin,
    .rx_frame_sync_pin, .tx_data_sync, .irq);

// ### sssr_regs_tb_top.sv
module sssr_regs_tb_top
    import sssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rx_word = 32'h0, reg_rdata;
    logic rx_load = 1'b0, rx_busy = 1'b0, rx_sync_capture = 1'b0;
    logic [SYNC_W-1:0] rx_sync_word = 16'h0000;
    logic tx_frame_sync_pin = 1'b0, rx_frame_sync_pin = 1'b0;
    logic tx_data_sync, irq;
    int failures = 0, check_count = 0, n;
    logic [7:0] regs [6] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h4C, 8'h50};
    sssr_regs DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_load(rx_load), .rx_word(rx_word),
        .rx_busy(rx_busy), .rx_sync_capture(rx_sync_capture),
        .rx_sync_word(rx_sync_word), .tx_frame_sync_pin(tx_frame_sync_pin),
        .rx_frame_sync_pin(rx_frame_sync_pin), .tx_data_sync(tx_data_sync),
        .irq(irq));
    always #5 clk_sys = ~clk_sys;
    // ---------------------------------------------------------------
    // bus tasks: strobes last exactly one cycle
    // ---------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // step off the edge so a following call never drives the strobe twice
        #1;
    endtask : wr
    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : idle
    task automatic cmp(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // read data stands one cycle only, so it is taken just after the edge
    task automatic rc(input logic [7:0] a, input logic [31:0] mk, e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        cmp($sformatf("reg %h", a), e, reg_rdata & mk);
    endtask : rc
    task automatic ld(input logic [31:0] w);
        rx_word <= w;
        rx_load <= 1'b1;
        @(posedge clk_sys);
        rx_load <= 1'b0;
        #1;
    endtask : ld
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        idle(6);
        rst <= 1'b0;
        idle(1);
        rc(OFS_EVENT_STATUS, '1, 32'h3);
        foreach (regs[i]) rc(regs[i], '1, 32'h0);
        $display("test reset done");
        foreach (regs[i]) if (i > 0 && i < 4) begin
            wr(regs[i], '1);
            rc(regs[i], '1, 32'h0000FFFF);
        end
        wr(OFS_RX_SYNC_HOLDING, '1);
        rc(OFS_RX_SYNC_HOLDING, '1, 32'h0);
        $display("test registers done");
        wr(OFS_IRQ_ENABLE_SET, '1);
        rc(OFS_IRQ_MASK_STATE, '1, 32'hF33);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h300);
        rc(OFS_IRQ_MASK_STATE, '1, 32'hC33);
        wr(OFS_IRQ_ENABLE_SET, 32'h0);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
        rc(OFS_IRQ_MASK_STATE, '1, 32'hC33);
        idle(2);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_ENABLE_CLEAR, '1);
        idle(2);
        cmp("irq", 32'h0, {31'h0, irq});
        $display("test mask done");
        wr(OFS_RX_COMPARE_A, 32'h1234);
        wr(OFS_RX_COMPARE_B, 32'h5678);
        wr(OFS_IRQ_ENABLE_SET, 32'h100);
        ld(32'h1234);
        ld(32'h5678);
        idle(6);
        cmp("irq", 32'h1, {31'h0, irq});
        rc(OFS_EVENT_STATUS, '1, 32'h333);
        rc(OFS_EVENT_STATUS, '1, 32'h13);
        idle(2);
        cmp("irq", 32'h0, {31'h0, irq});
        rc(OFS_RX_HOLDING, '1, 32'h5678);
        rc(OFS_EVENT_STATUS, '1, 32'h3);
        $display("test receive done");
        rx_sync_word <= 16'hABCD;
        rx_sync_capture <= 1'b1;
        idle(1);
        rx_sync_capture <= 1'b0;
        rc(OFS_RX_SYNC_HOLDING, '1, 32'hABCD);
        rx_frame_sync_pin <= 1'b1;
        idle(5);
        rc(OFS_EVENT_STATUS, 32'hC00, 32'h800);
        tx_frame_sync_pin <= 1'b1;
        idle(5);
        rc(OFS_EVENT_STATUS, 32'hC00, 32'h400);
        wr(OFS_SYNC_MODE, 32'h01000000);
        tx_frame_sync_pin <= 1'b0;
        rx_frame_sync_pin <= 1'b0;
        idle(5);
        rc(OFS_EVENT_STATUS, 32'hC00, 32'h400);
        tx_frame_sync_pin <= 1'b1;
        idle(5);
        rc(OFS_EVENT_STATUS, 32'hC00, 32'h0);
        // a sync word of all ones makes each shifted bit a high cycle
        wr(OFS_TX_SYNC_HOLDING, 32'hFFFF);
        wr(OFS_SYNC_MODE, 32'h00800003);
        tx_frame_sync_pin <= 1'b0;
        idle(4);
        tx_frame_sync_pin <= 1'b1;
        n = 0;
        repeat (30) begin
            idle(1);
            if (tx_data_sync === 1'b1) n++;
        end
        cmp("sync bits", 32'd4, n);
        $display("test sync done");
        wr(OFS_COMMAND, 32'h101);
        rc(OFS_EVENT_STATUS, 32'h30000, 32'h30000);
        rx_busy <= 1'b1;
        wr(OFS_COMMAND, 32'h2);
        idle(3);
        rc(OFS_EVENT_STATUS, 32'h30000, 32'h30000);
        rx_busy <= 1'b0;
        idle(3);
        rc(OFS_EVENT_STATUS, 32'h30000, 32'h10000);
        wr(OFS_TX_HOLDING, 32'h55);
        wr(OFS_COMMAND, 32'h200);
        rc(OFS_EVENT_STATUS, 32'h10002, 32'h10000);
        idle(30);
        rc(OFS_EVENT_STATUS, 32'h10003, 32'h3);
        wr(OFS_TX_HOLDING, 32'hAA);
        idle(2);
        rc(OFS_EVENT_STATUS, 32'h3, 32'h0);
        wr(OFS_COMMAND, 32'h100);
        idle(30);
        rc(OFS_EVENT_STATUS, 32'h3, 32'h3);
        $display("test enables done");
        end_sim();
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
endmodule : sssr_regs_tb_top
